/* cpg_defines.svh */
`ifndef CPG_DEFINES_SVH
`define CPG_DEFINES_SVH

// ************************************************************
// Register map
// ************************************************************
`define SYSCLK_CTRL_OFFSET     32'h0000_0000
`define LOWPWR_CTRL_OFFSET     32'h0000_0004
`define SYSCLK_CTRL_RESET      8'h00
`define LOWPWR_CTRL_RESET      8'h00
`define PLL_FACTOR_RESET       2'h0

// ************************************************************
// Field limits and bus answers
// ************************************************************
`define BMC_SELECT_MAX         3'h5
`define PLL_FACTOR_PROHIBITED  2'h3
`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

// ************************************************************
// Dividers and timing
// ************************************************************
`define MED_DIV_WIDTH          5
`define SUB_DIV_WIDTH          7
`define STANDBY_WAIT_BASE      16'h0010
`define WAIT_COUNT_ZERO        16'h0000
`define WAIT_COUNT_ONE         16'h0001

`endif

/* cpg_pkg.sv */
package cpg_pkg;

    typedef enum logic [3:0] {
        MODE_HIGH_SPEED   = 4'b0000,
        MODE_MEDIUM_SPEED = 4'b0001,
        MODE_SUBACTIVE    = 4'b0010,
        MODE_SLEEP        = 4'b0011,
        MODE_SUBSLEEP     = 4'b0100,
        MODE_SW_STANDBY   = 4'b0101,
        MODE_WATCH        = 4'b0110,
        MODE_DIRECT       = 4'b0111,
        MODE_HW_STANDBY   = 4'b1000
    } power_mode_t;

    typedef enum logic [1:0] {
        SEL_NONE   = 2'b00,
        SEL_SYSCLK = 2'b01,
        SEL_LOWPWR = 2'b10
    } reg_sel_t;

    typedef struct packed {
        logic       output_disable;
        logic       factor_switch_mode_select;
        logic [2:0] bus_master_clock_select;
    } system_clock_control_t;

    typedef struct packed {
        logic       direct_transition_on;
        logic       low_speed_on;
        logic       reserved_5;
        logic       subclock_stop;
        logic       feedback_resistor_cut;
        logic       reserved_2;
        logic [1:0] pll_factor;
    } low_power_control_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic       system_clock_pin_out;
        logic       system_clock_pin_oe_n;
        logic       bus_master_clock_enable;
        logic       subclock;
        logic [1:0] pll_factor;
        logic       feedback_resistor_on;
        logic       operation_ready;
        logic       direct_transition_on;
        logic       low_speed_on;
    } clock_out_t;

    typedef struct packed {
        system_clock_control_t scc;
        low_power_control_t    lpc;
        logic [1:0]            active_pll_factor;
        logic                  cut_active;
        logic                  feedback_on;
        logic                  aw_held;
        reg_sel_t              aw_sel;
        logic                  w_held;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic [1:0]            rresp;
        logic                  pin_level;
        logic                  pin_oe_n;
        logic                  bm_enable;
        power_mode_t           prev_mode;
        logic [15:0]           wait_count;
        logic                  op_ready;
    } cpg_state_t;

endpackage

/* free_divider.sv */
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Synchronous binary counter used as a clock divider
// ************************************************************
// While run is low the count is held at zero, so a stopped divider
// always restarts from a known phase.
module free_divider #(
    parameter int WIDTH = 7
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic             run,
    output var  logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] next_count;

    if (WIDTH < 1) begin : g_check
        $error("free_divider needs at least one stage");
    end

    always_comb begin
        next_count = '0;
        if (run) begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

endmodule

`default_nettype wire

/* clock_pulse_generator_control.sv */
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cpg_defines.svh"

// ************************************************************
// Clock pulse generator control with AXI4-Lite register access
// ************************************************************
// The system clock pin shows an image of the internal clock at half
// the bus clock rate, because a gated copy of aclk itself would glitch.
module clock_pulse_generator_control #(
    parameter int          SUB_DIV_WIDTH = `SUB_DIV_WIDTH,
    parameter logic [15:0] WAIT_BASE     = `STANDBY_WAIT_BASE
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    input  wire cpg_pkg::axil_req_t   axil_req,
    output var  cpg_pkg::axil_rsp_t   axil_rsp,
    input  wire cpg_pkg::power_mode_t power_mode,
    input  wire logic [2:0]           standby_timer_select,
    output var  cpg_pkg::clock_out_t  clock_out
);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    if (SUB_DIV_WIDTH != `SUB_DIV_WIDTH) begin : g_sub_check
        $error("Subclock divider must divide by 128");
    end
    if (WAIT_BASE == `WAIT_COUNT_ZERO || WAIT_BASE > 16'h01FF) begin : g_wb
        $error("Wait base must be nonzero and fit after a shift of 7");
    end

    // ********************************************************
    // State and dividers
    // ********************************************************
    cpg_pkg::cpg_state_t         s;
    cpg_pkg::cpg_state_t         next_s;
    logic [`MED_DIV_WIDTH-1:0]   med_count;
    logic [SUB_DIV_WIDTH-1:0]    sub_count;
    logic                        clocks_running;
    logic                        sub_running;

    // The oscillator is stopped in software standby, watch and
    // hardware standby, so every divider rests there.
    always_comb begin
        clocks_running = !(power_mode == cpg_pkg::MODE_SW_STANDBY ||
                           power_mode == cpg_pkg::MODE_WATCH ||
                           power_mode == cpg_pkg::MODE_HW_STANDBY);
        sub_running = clocks_running && !s.lpc.subclock_stop;
    end

    free_divider #(
        .WIDTH (`MED_DIV_WIDTH)
    ) medium_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .run     (clocks_running),
        .count   (med_count)
    );

    free_divider #(
        .WIDTH (SUB_DIV_WIDTH)
    ) sub_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .run     (sub_running),
        .count   (sub_count)
    );

    // ********************************************************
    // Address decode
    // ********************************************************
    function automatic cpg_pkg::reg_sel_t decode(input logic [31:0] addr);
        cpg_pkg::reg_sel_t sel;
        sel = cpg_pkg::SEL_NONE;
        if (addr == `SYSCLK_CTRL_OFFSET) begin
            sel = cpg_pkg::SEL_SYSCLK;
        end else if (addr == `LOWPWR_CTRL_OFFSET) begin
            sel = cpg_pkg::SEL_LOWPWR;
        end
        return sel;
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    logic [5:0]  span;
    logic        bm_hit;
    logic        entering_standby;
    logic        leaving_standby;

    always_comb begin
        next_s = s;

        // Divide by 2**select: the tick lands where the low bits are ones.
        span   = (6'h01 << s.scc.bus_master_clock_select) - 6'h01;
        bm_hit = (med_count & span[`MED_DIV_WIDTH-1:0]) ==
                 span[`MED_DIV_WIDTH-1:0];
        next_s.bm_enable = clocks_running && bm_hit;

        // Write address and data are taken independently.
        if (axil_req.awvalid && !s.aw_held && !s.bvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_sel  = decode(axil_req.awaddr);
        end
        if (axil_req.wvalid && !s.w_held && !s.bvalid) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = axil_req.wdata[7:0];
            next_s.wstrb0 = axil_req.wstrb[0];
        end

        if (s.bvalid && axil_req.bready) begin
            next_s.bvalid = 1'b0;
        end

        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `AXI_RESP_OKAY;
            unique case (s.aw_sel)
                cpg_pkg::SEL_SYSCLK: begin
                    if (s.wstrb0) begin
                        next_s.scc.output_disable = s.wdata[7];
                        next_s.scc.factor_switch_mode_select = s.wdata[3];
                        // A prohibited divider code keeps the old one.
                        if (s.wdata[2:0] <= `BMC_SELECT_MAX) begin
                            next_s.scc.bus_master_clock_select =
                                s.wdata[2:0];
                        end
                    end
                end
                cpg_pkg::SEL_LOWPWR: begin
                    if (s.wstrb0) begin
                        next_s.lpc.direct_transition_on  = s.wdata[7];
                        next_s.lpc.low_speed_on          = s.wdata[6];
                        next_s.lpc.reserved_5            = s.wdata[5];
                        next_s.lpc.subclock_stop         = s.wdata[4];
                        next_s.lpc.feedback_resistor_cut = s.wdata[3];
                        next_s.lpc.reserved_2            = s.wdata[2];
                        if (s.wdata[1:0] != `PLL_FACTOR_PROHIBITED) begin
                            next_s.lpc.pll_factor = s.wdata[1:0];
                            if (s.scc.factor_switch_mode_select) begin
                                next_s.active_pll_factor =
                                    s.wdata[1:0];
                            end
                        end
                    end
                end
                default: begin
                    next_s.bresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        if (s.rvalid && axil_req.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (axil_req.arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `AXI_RESP_OKAY;
            unique case (decode(axil_req.araddr))
                cpg_pkg::SEL_SYSCLK: begin
                    next_s.rdata = {s.scc.output_disable, 3'h0,
                                    s.scc.factor_switch_mode_select,
                                    s.scc.bus_master_clock_select};
                end
                cpg_pkg::SEL_LOWPWR: begin
                    next_s.rdata = s.lpc;
                end
                default: begin
                    next_s.rdata = 8'h00;
                    next_s.rresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // Standby entry: a deferred factor and a pending feedback cut
        // both take effect while the generator is stopped.
        entering_standby = power_mode == cpg_pkg::MODE_SW_STANDBY &&
                           s.prev_mode != cpg_pkg::MODE_SW_STANDBY;
        leaving_standby  = power_mode != cpg_pkg::MODE_SW_STANDBY &&
                           s.prev_mode == cpg_pkg::MODE_SW_STANDBY;
        next_s.prev_mode = power_mode;
        if (entering_standby) begin
            next_s.active_pll_factor = s.lpc.pll_factor;
            next_s.cut_active = s.lpc.feedback_resistor_cut;
            next_s.op_ready   = 1'b0;
        end

        // Recovery waits out the count picked by the standby timer select.
        if (leaving_standby) begin
            next_s.wait_count = 16'(WAIT_BASE << standby_timer_select);
        end else if (s.wait_count != `WAIT_COUNT_ZERO) begin
            next_s.wait_count = s.wait_count - `WAIT_COUNT_ONE;
            if (s.wait_count == `WAIT_COUNT_ONE) begin
                next_s.op_ready = 1'b1;
            end
        end

        next_s.feedback_on = !s.cut_active && clocks_running;

        unique case (power_mode)
            cpg_pkg::MODE_HIGH_SPEED, cpg_pkg::MODE_MEDIUM_SPEED,
            cpg_pkg::MODE_SUBACTIVE, cpg_pkg::MODE_SLEEP,
            cpg_pkg::MODE_SUBSLEEP: begin
                next_s.pin_oe_n = 1'b0;
                next_s.pin_level = s.scc.output_disable ? 1'b1
                                                        : !s.pin_level;
            end
            cpg_pkg::MODE_SW_STANDBY, cpg_pkg::MODE_WATCH,
            cpg_pkg::MODE_DIRECT: begin
                next_s.pin_oe_n  = 1'b0;
                next_s.pin_level = 1'b1;
            end
            cpg_pkg::MODE_HW_STANDBY: begin
                next_s.pin_oe_n  = 1'b1;
                next_s.pin_level = 1'b1;
            end
            default: begin
                next_s.pin_oe_n  = 1'b0;
                next_s.pin_level = 1'b1;
            end
        endcase
    end

    // ********************************************************
    // Register and reset
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s.scc               <= 5'(`SYSCLK_CTRL_RESET);
            s.lpc               <= `LOWPWR_CTRL_RESET;
            s.active_pll_factor <= `PLL_FACTOR_RESET;
            s.cut_active        <= 1'b0;
            s.feedback_on       <= 1'b1;
            s.aw_held           <= 1'b0;
            s.aw_sel            <= cpg_pkg::SEL_NONE;
            s.w_held            <= 1'b0;
            s.wdata             <= 8'h00;
            s.wstrb0            <= 1'b0;
            s.bvalid            <= 1'b0;
            s.bresp             <= `AXI_RESP_OKAY;
            s.rvalid            <= 1'b0;
            s.rdata             <= 8'h00;
            s.rresp             <= `AXI_RESP_OKAY;
            s.pin_level         <= 1'b1;
            s.pin_oe_n          <= 1'b0;
            s.bm_enable         <= 1'b0;
            s.prev_mode         <= cpg_pkg::MODE_HIGH_SPEED;
            s.wait_count        <= `WAIT_COUNT_ZERO;
            s.op_ready          <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    always_comb begin
        axil_rsp.awready = !s.aw_held && !s.bvalid;
        axil_rsp.wready  = !s.w_held && !s.bvalid;
        axil_rsp.bvalid  = s.bvalid;
        axil_rsp.bresp   = s.bresp;
        axil_rsp.arready = !s.rvalid;
        axil_rsp.rvalid  = s.rvalid;
        axil_rsp.rdata   = {24'h000000, s.rdata};
        axil_rsp.rresp   = s.rresp;

        clock_out.system_clock_pin_out    = s.pin_level;
        clock_out.system_clock_pin_oe_n   = s.pin_oe_n;
        clock_out.bus_master_clock_enable = s.bm_enable;
        clock_out.subclock = sub_count[SUB_DIV_WIDTH-1];
        clock_out.pll_factor              = s.active_pll_factor;
        clock_out.feedback_resistor_on    = s.feedback_on;
        clock_out.operation_ready         = s.op_ready;
        clock_out.direct_transition_on    = s.lpc.direct_transition_on;
        clock_out.low_speed_on            = s.lpc.low_speed_on;
    end

endmodule

`default_nettype wire

/* clock_pulse_generator_control_chk.sv */
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Port-level checks of the clock pulse generator control
// ************************************************************
module clock_pulse_generator_control_chk #(
    parameter int          SUB_DIV_WIDTH = 7,
    parameter logic [15:0] WAIT_BASE     = 16'h0010
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 ce,
    input wire cpg_pkg::axil_req_t   axil_req,
    input wire cpg_pkg::axil_rsp_t   axil_rsp,
    input wire cpg_pkg::power_mode_t power_mode,
    input wire logic [2:0]           standby_timer_select,
    input wire cpg_pkg::clock_out_t  clock_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    // Mode groups are decoded here so each property reads as the rule.
    wire logic stop_mode = power_mode == cpg_pkg::MODE_SW_STANDBY ||
                           power_mode == cpg_pkg::MODE_WATCH ||
                           power_mode == cpg_pkg::MODE_DIRECT;
    wire logic osc_off   = power_mode == cpg_pkg::MODE_SW_STANDBY ||
                           power_mode == cpg_pkg::MODE_WATCH ||
                           power_mode == cpg_pkg::MODE_HW_STANDBY;
    wire logic active    = power_mode <= cpg_pkg::MODE_SUBSLEEP;

    sequence write_taken;
        axil_req.awvalid && axil_rsp.awready &&
        axil_req.wvalid && axil_rsp.wready;
    endsequence
    sequence write_answer;
        ##[1:2] axil_rsp.bvalid;
    endsequence

    a_hw_float: assert property ((power_mode == cpg_pkg::MODE_HW_STANDBY) [*3]
        |-> clock_out.system_clock_pin_oe_n) else $error("pin not floating");
    a_stop_high: assert property ((stop_mode) [*3] |->
        clock_out.system_clock_pin_out && !clock_out.system_clock_pin_oe_n)
        else $error("pin not held high");
    a_pin_change: assert property ($changed(clock_out.system_clock_pin_out)
        |-> $past(active) || $past(active, 2)) else $error("pin moved idle");
    a_osc_off: assert property ((osc_off) [*3] |->
        !clock_out.bus_master_clock_enable && !clock_out.subclock &&
        !clock_out.feedback_resistor_on) else $error("clocks run stopped");
    a_ready_low: assert property ((power_mode == cpg_pkg::MODE_SW_STANDBY) [*2]
        |-> !clock_out.operation_ready) else $error("ready in standby");
    a_factor_legal: assert property (clock_out.pll_factor != 2'h3)
        else $error("factor code illegal");
    a_rdata_upper: assert property (axil_rsp.rvalid |->
        axil_rsp.rdata[31:8] == 24'h000000 &&
        (axil_rsp.rresp == 2'h0 || axil_rsp.rdata == 32'h00000000))
        else $error("read data bits set");
    a_write_answer: assert property (write_taken |-> write_answer)
        else $error("write answer late");
    a_b_stands: assert property (axil_rsp.bvalid && !axil_req.bready |=>
        axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("b dropped");
    a_r_stands: assert property (axil_rsp.rvalid && !axil_req.rready |=>
        axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("r dropped");
    a_read_answer: assert property (axil_req.arvalid && !axil_rsp.rvalid
        |=> axil_rsp.rvalid) else $error("read answer late");
endmodule

bind clock_pulse_generator_control clock_pulse_generator_control_chk #(
    .SUB_DIV_WIDTH(SUB_DIV_WIDTH),
    .WAIT_BASE(WAIT_BASE)
) chk_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .axil_req(axil_req),
    .axil_rsp(axil_rsp),
    .power_mode(power_mode),
    .standby_timer_select(standby_timer_select),
    .clock_out(clock_out)
);

`default_nettype wire

/* clock_pulse_generator_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpg_defines.svh"

module clock_pulse_generator_control_tb_top;
    logic                aclk;
    logic                aresetn;
    logic                ce;
    cpg_pkg::axil_req_t  req;
    cpg_pkg::axil_rsp_t  rsp;
    cpg_pkg::power_mode_t power_mode;
    logic [2:0]          tsel;
    cpg_pkg::clock_out_t co;
    int                  fails = 0;
    int                  checks = 0;

    // A short base wait keeps the standby recovery at eight cycles.
    clock_pulse_generator_control #(
        .SUB_DIV_WIDTH(7),
        .WAIT_BASE(16'h0004)
    ) clock_pulse_generator_control_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .axil_req(req),
        .axil_rsp(rsp),
        .power_mode(power_mode),
        .standby_timer_select(tsel),
        .clock_out(co)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Each task ends one edge after its answer, so calls never collide.
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      output logic [1:0] resp);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        resp = 2'h3;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        resp = 2'h3;
        d = 32'hFFFFFFFF;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                d = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask

    task automatic wreg(input logic [31:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        check("bresp", 32'h0, {30'h0, r});
    endtask

    task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check("rdata", exp, d);
        check("rresp", 32'h0, {30'h0, r});
    endtask

    task automatic go(input cpg_pkg::power_mode_t m);
        power_mode <= m;
        repeat (4) @(posedge aclk);
    endtask

    task automatic wait_ready(output int n);
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (co.operation_ready === 1'b1) break;
        end
    endtask

    // Kind 0 counts bus clock pulses, 1 subclock rises, 2 subclock highs
    // and 3 samples where the clock pin is not high.
    task automatic tally(input int len, input int kind, output int n);
        logic prev;
        n = 0;
        prev = co.subclock;
        repeat (len) begin
            @(posedge aclk);
            if (kind == 0 && co.bus_master_clock_enable === 1'b1) n++;
            if (kind == 1 && co.subclock === 1'b1 && prev === 1'b0) n++;
            if (kind == 2 && co.subclock !== 1'b0) n++;
            if (kind == 3 && co.system_clock_pin_out !== 1'b1) n++;
            prev = co.subclock;
        end
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        int          n;
        logic [31:0] d;
        logic [1:0]  r;
        req = '0;
        power_mode = cpg_pkg::MODE_HIGH_SPEED;
        tsel = 3'h1;
        ce = 1'b1;
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rreg(`SYSCLK_CTRL_OFFSET, 32'h0);
        rreg(`LOWPWR_CTRL_OFFSET, 32'h0);
        check("pll", 32'h0, {30'h0, co.pll_factor});
        $display("test reset done");

        wreg(`SYSCLK_CTRL_OFFSET, 8'hFF);
        rreg(`SYSCLK_CTRL_OFFSET, 32'h88);
        tally(8, 3, n);
        check("pin_fixed", 32'h0, n);
        wreg(`SYSCLK_CTRL_OFFSET, 8'h08);
        repeat (2) @(posedge aclk);
        tally(8, 3, n);
        check("pin_clock", 32'h4, n);
        for (int m = 5; m < 8; m++) begin
            go(cpg_pkg::power_mode_t'(m));
            tally(8, 3, n);
            check("pin_stop", 32'h0, n);
            check("pin_oe", 32'h0, {31'h0, co.system_clock_pin_oe_n});
        end
        go(cpg_pkg::MODE_HW_STANDBY);
        check("pin_float", 32'h1, {31'h0, co.system_clock_pin_oe_n});
        go(cpg_pkg::MODE_HIGH_SPEED);
        wait_ready(n);
        $display("test clock pin done");

        for (int s = 0; s < 6; s++) begin
            wreg(`SYSCLK_CTRL_OFFSET, 8'h08 | 8'(s));
            tally(64, 0, n);
            check("bm_rate", 32'(64 >> s), n);
        end
        wreg(`SYSCLK_CTRL_OFFSET, 8'h0E);
        rreg(`SYSCLK_CTRL_OFFSET, 32'h0D);
        $display("test bus clock done");

        wreg(`LOWPWR_CTRL_OFFSET, 8'h02);
        repeat (2) @(posedge aclk);
        check("pll_now", 32'h2, {30'h0, co.pll_factor});
        wreg(`LOWPWR_CTRL_OFFSET, 8'h03);
        rreg(`LOWPWR_CTRL_OFFSET, 32'h02);
        check("pll_keep", 32'h2, {30'h0, co.pll_factor});
        $display("test immediate factor done");

        wreg(`SYSCLK_CTRL_OFFSET, 8'h00);
        wreg(`LOWPWR_CTRL_OFFSET, 8'h09);
        check("pll_wait", 32'h2, {30'h0, co.pll_factor});
        check("fb_write", 32'h1, {31'h0, co.feedback_resistor_on});
        go(cpg_pkg::MODE_SW_STANDBY);
        check("rdy_low", 32'h0, {31'h0, co.operation_ready});
        check("fb_stop", 32'h0, {31'h0, co.feedback_resistor_on});
        tally(8, 0, n);
        check("bm_stop", 32'h0, n);
        power_mode <= cpg_pkg::MODE_HIGH_SPEED;
        wait_ready(n);
        check("rdy_wait", 32'h1, {31'h0, n >= 8 && n <= 12});
        check("pll_new", 32'h1, {30'h0, co.pll_factor});
        check("fb_cut", 32'h0, {31'h0, co.feedback_resistor_on});
        wreg(`LOWPWR_CTRL_OFFSET, 8'h01);
        go(cpg_pkg::MODE_SW_STANDBY);
        power_mode <= cpg_pkg::MODE_HIGH_SPEED;
        wait_ready(n);
        check("fb_auto", 32'h1, {31'h0, co.feedback_resistor_on});
        $display("test deferred factor done");

        tally(256, 1, n);
        check("sub_rate", 32'h2, n);
        wreg(`LOWPWR_CTRL_OFFSET, 8'hD1);
        repeat (2) @(posedge aclk);
        tally(200, 2, n);
        check("sub_stop", 32'h0, n);
        check("dt_ls", 32'h3, {30'h0, co.direct_transition_on, co.low_speed_on});
        $display("test subclock done");

        rd(32'h0000_0008, d, r);
        check("rresp_bad", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
        check("rdata_bad", 32'h0, d);
        wr(32'h0000_0008, 8'h55, r);
        check("bresp_bad", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
        rreg(`LOWPWR_CTRL_OFFSET, 32'hD1);
        $display("test unmapped done");
        close_out();
    end

    initial begin
        #(100 * 20000);
        fails++;
        close_out();
    end
endmodule

`default_nettype wire
